// ---- dv/psc_ctrl_tb.sv ----
// testbench of the switching configuration block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module psc_ctrl_tb;
    import psc_pkg::*;
    logic       clk_sys = 1'h0;
    logic       reset_n = 1'h0;
    logic       output_enable = 1'h0;
    logic       sync_in = 1'h0;
    logic       share_member = 1'h0;
    int         hi = 0;
    logic       pwm_out, diode_emulation, config_ready;
    logic [7:0] active_divisor;
    psc_req_s   req;
    psc_rsp_s   rsp;
    int         fail_count = 0;
    int         total_checks = 0;
    always #10 clk_sys = ~clk_sys;
    // sync driven at the programmed switching rate
    psc_ctrl psc_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(1'h1), .req(req), .rsp(rsp), .strap_freq_word(16'h012C),
        .bus_addr(7'h25), .sync_in(sync_in), .output_enable(output_enable),
        .duty_demand(8'hFF), .share_member(share_member), .share_pos(4'h0),
        .pwm_out(pwm_out), .diode_emulation(diode_emulation),
        .active_divisor(active_divisor), .config_ready(config_ready));
    psc_host_model psc_host_model_inst (.clk_sys(clk_sys), .req(req),
        .rsp(rsp));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task report_and_stop();
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
             input logic en, input logic [15:0] eq);
        logic     got;
        psc_rsp_s r;
        psc_host_model_inst.xfer(w, c, d, got, r);
        if (!got) begin
            fail_count++;
            report_and_stop();
        end
        `CHK(r.nak, en)
        if (!w) `CHK(r.data, eq)
    endtask : cmd
    // ------------------------------------------------------------------
    // sequence, output held off for frequency writes
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        `CHK(active_divisor, DIV_RST)
        `CHK(diode_emulation, 1'h0)
        reset_n <= 1'h1;
        for (int i = 0; i < 60 && config_ready !== 1'h1; i++) @(posedge clk_sys);
        if (config_ready !== 1'h1) begin
            fail_count++;
            report_and_stop();
        end
        #1;
        `CHK(active_divisor, 8'h64)
        cmd(1'h0, CMD_DUTY_CEIL, 16'h0000, 1'h0, DUTY_CEIL_RST);
        cmd(1'h1, CMD_DUTY_CEIL, 16'h0065, 1'h1, 16'h0000);
        cmd(1'h0, CMD_DUTY_CEIL, 16'h0000, 1'h0, DUTY_CEIL_RST);
        cmd(1'h0, CMD_EFFICIENCY, 16'h0000, 1'h0, 16'h0000);
        cmd(1'h1, CMD_EFFICIENCY, 16'h0001, 1'h0, 16'h0000);
        cmd(1'h1, CMD_EFFICIENCY, 16'h0003, 1'h1, 16'h0000);
        `CHK(diode_emulation, 1'h1)
        cmd(1'h1, CMD_SW_FREQ, 16'h03E8, 1'h0, 16'h0000);
        `CHK(active_divisor, DIV_MIN)
        cmd(1'h1, CMD_SW_FREQ, 16'h01F4, 1'h0, 16'h0000);
        `CHK(active_divisor, 8'h3C)
        cmd(1'h1, CMD_SW_FREQ, 16'h014D, 1'h0, 16'h0000);
        `CHK(active_divisor, 8'h5A)
        cmd(1'h1, CMD_SW_FREQ, 16'h03E9, 1'h1, 16'h0000);
        cmd(1'h1, CMD_SW_FREQ, 16'h00C7, 1'h1, 16'h0000);
        `CHK(active_divisor, 8'h5A)
        @(posedge clk_sys);
        output_enable <= 1'h1;
        repeat (300) @(posedge clk_sys);
        repeat (150) begin
            @(posedge clk_sys);
            hi += pwm_out;
        end
        // 90 percent of a 150-clock period
        `CHK(hi, 135)
        share_member <= 1'h1;
        repeat (2) begin
            sync_in <= 1'h1;
            repeat (75) @(posedge clk_sys);
            `CHK(pwm_out, 1'h1)
            sync_in <= 1'h0;
            repeat (72) @(posedge clk_sys);
            `CHK(pwm_out, 1'h0)
            repeat (3) @(posedge clk_sys);
        end
        output_enable <= 1'h0;
        cmd(1'h0, CMD_PHASE_POS, 16'h0000, 1'h0, 16'h0005);
        cmd(1'h1, CMD_PHASE_POS, 16'h0010, 1'h1, 16'h0000);
        cmd(1'h0, CMD_PHASE_POS, 16'h0000, 1'h0, 16'h0005);
        cmd(1'h0, 8'h35, 16'h0000, 1'h1, 16'h0000);
        report_and_stop();
    end
endmodule : psc_ctrl_tb

// ---- dv/psc_host_model.sv ----
// host model that issues configuration commands to the block
`timescale 1ns/1ps
module psc_host_model
    import psc_pkg::*;
(
    input  wire logic     clk_sys,
    output psc_req_s      req,
    input  wire psc_rsp_s rsp
);
    // ------------------------------------------------------------------
    // command transfer
    // ------------------------------------------------------------------
    initial req = '0;
    // ceiling written only as a guard, never as a voltage control
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] d, output logic got,
                        output psc_rsp_s r);
        got = 1'h0;
        r   = '0;
        @(posedge clk_sys);
        req <= '{valid: 1'h1, write: w, code: c, data: d};
        @(posedge clk_sys);
        req <= '0;
        for (int i = 0; i < 4 && !got; i++) begin
            #1;
            if (rsp.valid === 1'h1) begin
                got = 1'h1;
                r   = rsp;
            end else begin
                @(posedge clk_sys);
            end
        end
    endtask : xfer
endmodule : psc_host_model

// ---- src/psc_ctrl.sv ----
// switching configuration command block, top level
//
// Operation
// - output on-time never exceeds the stored duty ceiling; reset is 90 percent.
// - out-of-range writes are refused and the old setting stays.
// - switching frequency is 30 MHz over n, n from 30 to 150.
// - written frequency rounds to the nearest integer divisor.
// - frequency starts from the frequency strap word if it is in range; a valid write overrides it.
// - efficiency bit 0 enables diode emulation; bits 15:1 must be zero; reset off.
// - switching phase is offset from the shared sync by the position.
// - position resets from the low four bits of the bus address.
// - in a current-share group positions come automatically unless written.
// - position field 3:0, zero means sixteen, 22.5 degrees per step.
`timescale 1ns/1ps
module psc_ctrl
    import psc_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire psc_req_s      req,
    output psc_rsp_s           rsp,
    input  wire logic [15:0]   strap_freq_word,
    input  wire logic [6:0]    bus_addr,
    input  wire logic          sync_in,
    input  wire logic          output_enable,
    input  wire logic [7:0]    duty_demand,
    input  wire logic          share_member,
    input  wire logic [3:0]    share_pos,
    output logic               pwm_out,
    output logic               diode_emulation,
    output logic [7:0]         active_divisor,
    output logic               config_ready
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    psc_pins_s pins_in;
    psc_pins_s s1_q, s2_q, s3_q;
    logic      sync_lvl_q, sync_lvl_d;
    logic      sync_edge;

    assign pins_in = '{freq_word: strap_freq_word, addr: bus_addr,
                       sync: sync_in};

    always_comb begin
        sync_lvl_d = sync_lvl_q;
        if (s2_q.sync == s3_q.sync) begin
            sync_lvl_d = s3_q.sync;
        end
    end

    assign sync_edge = sync_lvl_d && !sync_lvl_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s1_q       <= '0;
            s2_q       <= '0;
            s3_q       <= '0;
            sync_lvl_q <= 1'b0;
        end else if (clk_en) begin
            s1_q       <= pins_in;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            sync_lvl_q <= sync_lvl_d;
        end
    end

    // ------------------------------------------------------------------
    // linear decode and range checks
    // ------------------------------------------------------------------
    psc_boot_e          boot_q, boot_d;
    logic [1:0]         settle_q, settle_d;
    logic [15:0]        dec_word;
    logic [FX_W-1:0]    dec_fx;
    logic               dec_neg;
    logic               dec_ovf;
    logic               duty_ok;
    logic               freq_ok;
    logic [FX_W-1:0]    div_den;
    logic [FX_W-1:0]    div_x2;
    logic [7:0]         div_round;

    assign dec_word = (boot_q == BOOT_RUN) ? req.data : s3_q.freq_word;

    psc_lin_dec u_dec (
        .clk_sys  (clk_sys),
        .word     (dec_word),
        .value_fx (dec_fx),
        .neg      (dec_neg),
        .ovf      (dec_ovf)
    );

    always_comb begin
        duty_ok   = !dec_neg && !dec_ovf && (dec_fx <= DUTY_MAX_FX);
        freq_ok   = !dec_neg && !dec_ovf && (dec_fx >= FREQ_MIN_FX)
                    && (dec_fx <= FREQ_MAX_FX);
        div_den   = (dec_fx == '0) ? FX_W'(1) : dec_fx;
        div_x2    = DIV_NUM_X2 / div_den;
        div_round = 8'((div_x2 + FX_W'(1)) >> 1);
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [15:0]        duty_q, duty_d;
    logic [FX_W-1:0]    duty_fx_q, duty_fx_d;
    logic [15:0]        freq_q, freq_d;
    logic [7:0]         div_q, div_d;
    logic               eff_q, eff_d;
    logic [3:0]         phase_q, phase_d;
    logic               override_q, override_d;
    psc_rsp_s           rsp_q, rsp_d;
    logic [3:0]         phase_eff;
    logic               accept;

    always_comb begin
        boot_d     = boot_q;
        settle_d   = settle_q;
        duty_d     = duty_q;
        duty_fx_d  = duty_fx_q;
        freq_d     = freq_q;
        div_d      = div_q;
        eff_d      = eff_q;
        phase_d    = phase_q;
        override_d = override_q;
        accept     = 1'b0;
        rsp_d      = '{valid: req.valid, nak: 1'b1, data: 16'h0000};
        case (boot_q)
            BOOT_WAIT: begin
                if (settle_q != STRAP_SETTLE) begin
                    settle_d = settle_q + 2'h1;
                end else if (s2_q.freq_word == s3_q.freq_word
                             && s2_q.addr == s3_q.addr) begin
                    boot_d = BOOT_LOAD;
                end
            end
            BOOT_LOAD: begin
                phase_d = s3_q.addr[PHASE_POS_W-1:0];
                if (freq_ok) begin
                    freq_d = s3_q.freq_word;
                    div_d  = div_round;
                end
                boot_d = BOOT_RUN;
            end
            BOOT_RUN: begin
                if (req.valid && req.write) begin
                    case (req.code)
                        CMD_DUTY_CEIL: begin
                            accept = duty_ok;
                            if (duty_ok) begin
                                duty_d    = req.data;
                                duty_fx_d = dec_fx;
                            end
                        end
                        CMD_SW_FREQ: begin
                            accept = freq_ok;
                            if (freq_ok) begin
                                freq_d = req.data;
                                div_d  = div_round;
                            end
                        end
                        CMD_EFFICIENCY: begin
                            accept = (req.data[15:1] == 15'h0000);
                            if (accept) begin
                                eff_d = req.data[EFF_DIODE_BIT];
                            end
                        end
                        CMD_PHASE_POS: begin
                            accept = (req.data[15:PHASE_POS_W] == 12'h000);
                            if (accept) begin
                                phase_d    = req.data[PHASE_POS_W-1:0];
                                override_d = 1'b1;
                            end
                        end
                        default: begin
                            accept = 1'b0;
                        end
                    endcase
                    rsp_d.nak = !accept;
                end else if (req.valid) begin
                    rsp_d.nak = 1'b0;
                    case (req.code)
                        CMD_DUTY_CEIL:  rsp_d.data = duty_q;
                        CMD_SW_FREQ:    rsp_d.data = freq_q;
                        CMD_EFFICIENCY: rsp_d.data = {15'h0000, eff_q};
                        CMD_PHASE_POS:  rsp_d.data = {12'h000, phase_q};
                        default: begin
                            rsp_d.nak = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                boot_d = BOOT_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            boot_q     <= BOOT_WAIT;
            settle_q   <= 2'h0;
            duty_q     <= DUTY_CEIL_RST;
            duty_fx_q  <= DUTY_CEIL_FX_RST;
            freq_q     <= SW_FREQ_RST;
            div_q      <= DIV_RST;
            eff_q      <= EFF_DIODE_RST;
            phase_q    <= PHASE_POS_RST;
            override_q <= 1'b0;
            rsp_q      <= '0;
        end else if (clk_en) begin
            boot_q     <= boot_d;
            settle_q   <= settle_d;
            duty_q     <= duty_d;
            duty_fx_q  <= duty_fx_d;
            freq_q     <= freq_d;
            div_q      <= div_d;
            eff_q      <= eff_d;
            phase_q    <= phase_d;
            override_q <= override_d;
            rsp_q      <= rsp_d;
        end
    end

    assign phase_eff = (share_member && !override_q) ? share_pos
                                                      : phase_q;

    // ------------------------------------------------------------------
    // switching core
    // ------------------------------------------------------------------
    psc_pwm_core u_core (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .clk_en       (clk_en),
        .run          (output_enable && boot_q == BOOT_RUN),
        .div          (div_q),
        .duty_ceil_fx (duty_fx_q),
        .demand       (duty_demand),
        .phase_pos    (phase_eff),
        .sync_edge    (sync_edge),
        .pwm_out      (pwm_out)
    );

    assign rsp             = rsp_q;
    assign diode_emulation = eff_q;
    assign active_divisor  = div_q;
    assign config_ready    = (boot_q == BOOT_RUN);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [FX_W-1:0] chk_fx_q;
    logic [31:0]     chk_prod;
    logic [31:0]     chk_err;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            chk_fx_q <= '0;
        end else if (clk_en) begin
            chk_fx_q <= dec_fx;
        end
    end

    assign chk_prod = 32'(div_q) * 32'(chk_fx_q);
    assign chk_err  = (chk_prod > 32'(REF_KHZ_FX))
                      ? chk_prod - 32'(REF_KHZ_FX)
                      : 32'(REF_KHZ_FX) - chk_prod;

    property p_reject_keep;
        @(posedge clk_sys) disable iff (!reset_n)
        ($past(clk_en) && rsp_q.valid && rsp_q.nak) |->
            ($stable(duty_q) && $stable(freq_q) && $stable(div_q)
             && $stable(eff_q) && $stable(phase_q));
    endproperty
    a_reject_keep: assert property (p_reject_keep)
        else $error("refused write changed a setting");

    property p_div_range;
        @(posedge clk_sys) disable iff (!reset_n)
        (div_q >= DIV_MIN) && (div_q <= DIV_MAX);
    endproperty
    a_div_range: assert property (p_div_range)
        else $error("divisor outside allowed span");

    property p_round;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && boot_q == BOOT_RUN && req.valid && req.write
         && req.code == CMD_SW_FREQ && freq_ok)
        |=> (chk_err <= (32'(chk_fx_q) >> 1));
    endproperty
    a_round: assert property (p_round)
        else $error("divisor not nearest to requested frequency");

    property p_strap_load;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && boot_q == BOOT_LOAD && freq_ok) |=>
            (freq_q == $past(s3_q.freq_word)) && (boot_q == BOOT_RUN);
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("strapped frequency not loaded");

    property p_eff_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && boot_q == BOOT_RUN && req.valid && !req.write
         && req.code == CMD_EFFICIENCY)
        |=> (!rsp_q.nak && rsp_q.data[15:1] == 15'h0000
             && rsp_q.data[0] == diode_emulation);
    endproperty
    a_eff_read: assert property (p_eff_read)
        else $error("efficiency readback wrong");

    property p_phase_reset;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && boot_q == BOOT_LOAD) |=>
            (phase_q == $past(s3_q.addr[3:0])) && !override_q;
    endproperty
    a_phase_reset: assert property (p_phase_reset)
        else $error("position not taken from bus address");

    property p_share_auto;
        @(posedge clk_sys) disable iff (!reset_n)
        (share_member && !override_q) |-> (u_core.phase_pos == share_pos);
    endproperty
    a_share_auto: assert property (p_share_auto)
        else $error("group position not applied");

    c_freq_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
        rsp_q.valid && !rsp_q.nak && $changed(div_q));
    c_reject: cover property (@(posedge clk_sys) disable iff (!reset_n)
        rsp_q.valid && rsp_q.nak && boot_q == BOOT_RUN);

endmodule : psc_ctrl

// ---- src/psc_lin_dec.sv ----
// linear-11 word to unsigned fixed point decoder
`timescale 1ns/1ps
module psc_lin_dec
    import psc_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic [15:0]   word,
    output logic [FX_W-1:0]    value_fx,
    output logic               neg,
    output logic               ovf
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic signed [4:0]  exp_n;
    logic signed [10:0] man_y;
    logic signed [5:0]  shift;
    logic [10:0]        mag;
    logic [39:0]        wide;

    assign exp_n = word[15:LIN_EXP_LSB];
    assign man_y = word[LIN_MAN_MSB:0];
    assign shift = 6'(exp_n) + 6'sd8;

    always_comb begin
        mag  = man_y[10] ? 11'(-man_y) : 11'(man_y);
        wide = {29'h0, mag};
        if (shift >= 0) begin
            wide = wide << 6'(shift);
        end else begin
            wide = wide >> 6'(-shift);
        end
    end

    assign neg      = man_y[10];
    assign ovf      = |wide[39:FX_W];
    assign value_fx = wide[FX_W-1:0];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_lin_unity;
        @(posedge clk_sys) (exp_n == 5'sd0 && !neg) |->
            (value_fx == (FX_W'(mag) << FX_FRAC));
    endproperty
    a_lin_unity: assert property (p_lin_unity)
        else $error("linear decode with zero exponent wrong");

endmodule : psc_lin_dec

// ---- src/psc_pkg.sv ----
// shared constants and types of the switching configuration block
package psc_pkg;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_DUTY_CEIL     = 8'h32;
    localparam logic [7:0]  CMD_SW_FREQ       = 8'h33;
    localparam logic [7:0]  CMD_EFFICIENCY    = 8'h34;
    localparam logic [7:0]  CMD_PHASE_POS     = 8'h37;

    // ------------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [15:0] DUTY_CEIL_RST     = 16'hEAD0;
    localparam logic [23:0] DUTY_CEIL_FX_RST  = 24'h005A00;
    localparam logic [15:0] SW_FREQ_RST       = 16'h0000;
    localparam logic        EFF_DIODE_RST     = 1'b0;
    localparam logic [3:0]  PHASE_POS_RST     = 4'h0;
    localparam int          LIN_EXP_LSB       = 11;
    localparam int          LIN_MAN_MSB       = 10;
    localparam int          FX_FRAC           = 8;
    localparam int          FX_W              = 24;
    localparam int          EFF_DIODE_BIT     = 0;
    localparam int          PHASE_POS_W       = 4;
    localparam logic [4:0]  PHASE_STEPS       = 5'h10;

    // ------------------------------------------------------------------
    // ranges, in value x 2^FX_FRAC; divisor limits as plain counts
    // ------------------------------------------------------------------
    localparam logic [23:0] DUTY_MAX_FX       = 24'h006400;
    localparam logic [23:0] FREQ_MIN_FX       = 24'h00C800;
    localparam logic [23:0] FREQ_MAX_FX       = 24'h03E800;
    localparam logic [23:0] REF_KHZ_FX        = 24'h753000;
    localparam logic [23:0] DIV_NUM_X2        = 24'hEA6000;
    localparam logic [7:0]  DIV_MIN           = 8'h1E;
    localparam logic [7:0]  DIV_MAX           = 8'h96;
    localparam logic [7:0]  DIV_RST           = 8'h4B;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          SYS_CLK_NS        = 20;
    localparam int          SYS_MHZ           = 1000 / SYS_CLK_NS;
    localparam int          REF_MHZ           = 30;
    localparam logic [1:0]  STRAP_SETTLE      = 2'h3;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } psc_req_s;

    typedef struct packed {
        logic        valid;
        logic        nak;
        logic [15:0] data;
    } psc_rsp_s;

    typedef struct packed {
        logic [15:0] freq_word;
        logic [6:0]  addr;
        logic        sync;
    } psc_pins_s;

    typedef enum logic [1:0] {
        BOOT_WAIT = 2'b00,
        BOOT_LOAD = 2'b01,
        BOOT_RUN  = 2'b10
    } psc_boot_e;

endpackage : psc_pkg

// ---- src/psc_pwm_core.sv ----
// switching counter, phase offset and duty limiting
`timescale 1ns/1ps
module psc_pwm_core
    import psc_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              run,
    input  wire logic [7:0]        div,
    input  wire logic [FX_W-1:0]   duty_ceil_fx,
    input  wire logic [7:0]        demand,
    input  wire logic [3:0]        phase_pos,
    input  wire logic              sync_edge,
    output logic                   pwm_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [6:0]  acc_q,  acc_d;
    logic [7:0]  cnt_q,  cnt_d;
    logic [7:0]  div_q,  div_d;
    logic        pwm_q,  pwm_d;
    logic        tick;
    logic [4:0]  pos_eff;
    logic [8:0]  offset;
    logic [7:0]  load_val;
    logic [31:0] lim_prod;
    logic [7:0]  on_lim;
    logic [15:0] req_prod;
    logic [7:0]  on_cnt;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        // reference ticks at REF_MHZ out of the system clock
        acc_d = acc_q + 7'(REF_MHZ);
        tick  = 1'b0;
        if (acc_d >= 7'(SYS_MHZ)) begin
            acc_d = acc_d - 7'(SYS_MHZ);
            tick  = 1'b1;
        end
        pos_eff  = (phase_pos == 4'h0) ? PHASE_STEPS : {1'b0, phase_pos};
        offset   = 9'((13'(pos_eff) * 13'(div_q)) >> PHASE_POS_W);
        load_val = (offset >= 9'(div_q)) ? 8'h00 : 8'(9'(div_q) - offset);
        lim_prod = (32'(duty_ceil_fx) * 32'(div_q)) / 32'(DUTY_MAX_FX);
        on_lim   = 8'(lim_prod);
        req_prod = (16'(demand) * 16'(div_q)) >> 8;
        on_cnt   = (8'(req_prod) > on_lim) ? on_lim : 8'(req_prod);
        div_d    = div_q;
        cnt_d    = cnt_q;
        if (sync_edge) begin
            cnt_d = load_val;
        end else if (tick) begin
            if (cnt_q >= div_q - 8'h01) begin
                cnt_d = 8'h00;
                div_d = div;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
        pwm_d = run && (cnt_q < on_cnt);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= 7'h00;
            cnt_q <= 8'h00;
            div_q <= DIV_RST;
            pwm_q <= 1'b0;
        end else if (clk_en) begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            pwm_q <= pwm_d;
        end
    end

    assign pwm_out = pwm_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_duty_cap;
        @(posedge clk_sys) disable iff (!reset_n)
        ($past(clk_en) && pwm_q) |-> ($past(cnt_q) < $past(on_lim));
    endproperty
    a_duty_cap: assert property (p_duty_cap)
        else $error("output high beyond duty ceiling");

    property p_cnt_range;
        @(posedge clk_sys) disable iff (!reset_n)
        (cnt_q < div_q) && (div_q >= DIV_MIN) && (div_q <= DIV_MAX);
    endproperty
    a_cnt_range: assert property (p_cnt_range)
        else $error("switching counter outside divisor");

    property p_sync_phase;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && sync_edge && phase_pos == 4'h0) |=> (cnt_q == 8'h00);
    endproperty
    a_sync_phase: assert property (p_sync_phase)
        else $error("position zero not aligned to sync");

    c_sync: cover property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && sync_edge && phase_pos == 4'h1);

endmodule : psc_pwm_core
